// >>> flash_port_pkg.sv
// constants shared by the flash host port device end, host end, word store and bench
// assumes a single 100 MHz clock and an active-low asynchronous reset on both ends
//
// Functional notes
// - width strap high gives 16-bit, low 8-bit
// - 8-bit mode ignores upper data byte lines
// - shared pin is a0 narrow, power-down otherwise
// - power-down input enters and leaves deep power-down
// - two-bit cascade strap, up to four devices
// - board straps positions 00,01,10,11; lone uses 00
// - lock low protects selected partitions read/write
// - busy low while initializing; host waits
// - upper-byte pullups enabled only in 8-bit mode
// - dma request is active-low open drain
// - interrupt request is active-low open drain
// - host drives select and strobes active low
// - device decodes 13-bit address bus
package flash_port_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int CASC_W = 2;
  localparam int WORDS  = 16;
  localparam int IDX_W  = 4;
  localparam int NPART  = 2;
  // window layout: cascade position selects the top two address bits
  localparam int CASC_LSB = 11;
  localparam int IDX_LSB  = 1;
  localparam int PART_BIT = 4;
  // control words inside the local window
  localparam logic [IDX_W-1:0] IDX_CTRL   = 4'hE;
  localparam logic [IDX_W-1:0] IDX_STATUS = 4'hF;
  localparam int CTL_DMA    = 0;
  localparam int CTL_IRQ    = 1;
  localparam int CTL_PROT0  = 2;
  localparam int CTL_PROT1  = 3;
  // initialization time after reset
  localparam int INIT_NS     = 1000;
  localparam int CLK_NS      = 10;
  localparam int INIT_CYCLES = (INIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] INIT_CNT = 8'(INIT_CYCLES);
  localparam logic [DATA_W-1:0] PROT_READ = 16'hFFFF;
  // host avalon map
  localparam logic [3:0] AV_CMD    = 4'h0;
  localparam logic [3:0] AV_WDATA  = 4'h4;
  localparam logic [3:0] AV_RDATA  = 4'h8;
  localparam logic [3:0] AV_STATUS = 4'hC;
  localparam int STROBE_CYCLES = 4;
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_SETUP = 2'b01,
    H_STROBE = 2'b10,
    H_DONE  = 2'b11
  } host_state_t;
endpackage : flash_port_pkg

// >>> flash_port_if.sv
// pin carrier between host end and flash device end
// resolves the open-drain and two-way wires here from the enables
`timescale 1ns/1ps
interface flash_port_if;
  logic [12:0] addr;
  logic [15:0] data_h;
  logic [15:0] data_d;
  logic        data_d_oe;
  logic        data_h_oe;
  logic        chip_select_n;
  logic        write_n;
  logic        read_n;
  logic        deep_power_down_in;
  logic        reset_in_n;
  logic        busy_oe;
  logic        dma_request_oe;
  logic        irq_oe;
  logic        narrow_mode_pullup;
  // open-drain levels as seen by the host: low while driven
  wire busy_n        = ~busy_oe;
  wire dma_request_n = ~dma_request_oe;
  wire irq_n         = ~irq_oe;
  // bus seen by each end; undriven upper byte floats to pulled-up level in narrow mode
  wire [15:0] bus = data_h_oe ? data_h : (data_d_oe ? data_d : 16'hFFFF);
  modport dev (input addr, bus, chip_select_n, write_n, read_n, deep_power_down_in, reset_in_n,
               output data_d, data_d_oe, busy_oe, dma_request_oe, irq_oe, narrow_mode_pullup);
  modport host (input bus, busy_n, dma_request_n, irq_n,
                output addr, data_h, data_h_oe, chip_select_n, write_n, read_n,
                       deep_power_down_in, reset_in_n);
endinterface : flash_port_if

// >>> flash_word_store.sv
// small flip-flop word store with per-word write enable
// assumes writes come one per cycle from the device end
`timescale 1ns/1ps
module flash_word_store (
  input  wire logic                                  clock,
  input  wire logic                                  rstn,
  input  wire logic                                  we,
  input  wire logic [flash_port_pkg::IDX_W-1:0]      idx,
  input  wire logic [flash_port_pkg::DATA_W-1:0]     wdata,
  input  wire logic [flash_port_pkg::DATA_W-1:0]     wmask,
  output logic      [flash_port_pkg::DATA_W-1:0]     rdata
);
  logic [flash_port_pkg::DATA_W-1:0] mem_ff [flash_port_pkg::WORDS];
  // one register per entry; mask keeps the unused byte in narrow mode
  for (genvar i = 0; i < flash_port_pkg::WORDS; i++) begin : g_word
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        mem_ff[i] <= 16'h0000;
      end else if (we && idx == i[flash_port_pkg::IDX_W-1:0]) begin
        mem_ff[i] <= (mem_ff[i] & ~wmask) | (wdata & wmask);
      end
    end
  end
  assign rdata = mem_ff[idx];
endmodule : flash_word_store

// >>> flash_dev_end.sv
// device end of the parallel host port: straps, window decode, protection, busy
// assumes host strobes are synchronous to clock and held at least two cycles
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module flash_dev_end (
  input  wire logic                clock,
  input  wire logic                rstn,
  flash_port_if.dev                pins,
  input  wire logic                width16_strap,
  input  wire logic [1:0]          cascade_position,
  input  wire logic                lock_n,
  input  wire logic                dma_event,
  input  wire logic                irq_event,
  output logic                     power_down,
  output logic                     initializing
);
  logic [7:0]  init_ff;
  logic        wide_ff;
  logic [1:0]  pos_ff;
  logic        pd_ff;
  logic        wr_d_ff;
  logic [15:0] rdata_ff;
  logic        oe_ff;
  logic [3:0]  ctrl_ff;
  logic        dma_ff;
  logic        irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // reset and straps: straps sampled on every init cycle; the value from the last init cycle is kept
  wire dev_rst_n = rstn & pins.reset_in_n;
  always_ff @(posedge clock or negedge dev_rst_n) begin
    if (!dev_rst_n) begin
      init_ff <= flash_port_pkg::INIT_CNT;
      wide_ff <= 1'b1;
      pos_ff  <= 2'b00;
    end else if (init_ff != 8'h00) begin
      init_ff <= init_ff - 8'h01;
      wide_ff <= width16_strap;
      pos_ff  <= cascade_position;
    end
  end
  assign initializing            = (init_ff != 8'h00);
  assign pins.busy_oe            = initializing;
  assign pins.narrow_mode_pullup = ~wide_ff;

  ////////////////////////////////////////////////////////////////////////////
  // address decode; the shared pin is a0 only when narrow
  wire        a0        = wide_ff ? 1'b0 : pins.addr[0];
  wire [12:0] eff_addr  = {pins.addr[flash_port_pkg::ADDR_W-1:1], a0};
  wire        pos_hit   = eff_addr[flash_port_pkg::CASC_LSB +: flash_port_pkg::CASC_W] == pos_ff;
  wire        sel       = ~pins.chip_select_n & pos_hit & ~initializing & ~pd_ff;
  wire [3:0]  idx       = eff_addr[flash_port_pkg::IDX_LSB +: flash_port_pkg::IDX_W];
  wire        part      = eff_addr[flash_port_pkg::PART_BIT];
  wire        part_prot = ~lock_n & (part ? ctrl_ff[flash_port_pkg::CTL_PROT1]
                                          : ctrl_ff[flash_port_pkg::CTL_PROT0]);
  wire        is_ctrl   = (idx == flash_port_pkg::IDX_CTRL);
  wire        is_stat   = (idx == flash_port_pkg::IDX_STATUS);
  wire        wr_now    = sel & ~pins.write_n;
  wire        wr_edge   = wr_now & ~wr_d_ff;
  wire        rd_now    = sel & ~pins.read_n;
  // narrow mode takes the low byte only; the odd address steers it high
  wire [15:0] wmask     = wide_ff ? 16'hFFFF : (a0 ? 16'hFF00 : 16'h00FF);
  wire [15:0] wdata     = wide_ff ? pins.bus : {pins.bus[7:0], pins.bus[7:0]};
  wire        store_we  = wr_edge & ~is_ctrl & ~is_stat & ~part_prot;
  wire [15:0] store_q;
  wire [15:0] status_w  = {10'h000, pos_ff, ~lock_n, wide_ff, irq_ff, dma_ff};
  wire [15:0] word_q    = is_stat ? status_w : (is_ctrl ? {12'h000, ctrl_ff}
                                  : (part_prot ? flash_port_pkg::PROT_READ : store_q));
  wire [15:0] rd_q      = wide_ff ? word_q : {8'h00, (a0 ? word_q[15:8] : word_q[7:0])};

  flash_word_store u_store (
    .clock (clock),
    .rstn  (dev_rst_n),
    .we    (store_we),
    .idx   (idx),
    .wdata (wdata),
    .wmask (wmask),
    .rdata (store_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // strobes, control word, power-down level
  always_ff @(posedge clock or negedge dev_rst_n) begin
    if (!dev_rst_n) begin
      wr_d_ff  <= 1'b0;
      ctrl_ff  <= 4'h0;
      pd_ff    <= 1'b0;
      rdata_ff <= 16'h0000;
      oe_ff    <= 1'b0;
    end else begin
      wr_d_ff  <= wr_now;
      pd_ff    <= wide_ff & ~initializing & pins.deep_power_down_in;
      rdata_ff <= rd_q;
      oe_ff    <= rd_now;
      if (wr_edge && is_ctrl) begin
        ctrl_ff <= wdata[3:0];
      end
    end
  end
  // upper byte driven as zero in narrow mode
  assign pins.data_d    = wide_ff ? rdata_ff : {8'h00, rdata_ff[7:0]};
  assign pins.data_d_oe = oe_ff & ~pins.read_n;
  assign power_down     = pd_ff;

  ////////////////////////////////////////////////////////////////////////////
  // request flags: event wins over clear; pulling low is the only drive
  wire clr_flags = wr_edge & is_stat;
  always_ff @(posedge clock or negedge dev_rst_n) begin
    if (!dev_rst_n) begin
      dma_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      dma_ff <= dma_event | (dma_ff & ~(clr_flags & wdata[flash_port_pkg::CTL_DMA]));
      irq_ff <= irq_event | (irq_ff & ~(clr_flags & wdata[flash_port_pkg::CTL_IRQ]));
    end
  end
  assign pins.dma_request_oe = dma_ff & ctrl_ff[flash_port_pkg::CTL_DMA];
  assign pins.irq_oe         = irq_ff & ctrl_ff[flash_port_pkg::CTL_IRQ];
endmodule : flash_dev_end

// >>> flash_host_end.sv
// host end: avalon-mm slave that runs one pin-level read or write per command
// assumes the device end on the far side of the carrier
`timescale 1ns/1ps
module flash_host_end (
  input  wire logic          clock,
  input  wire logic          rstn,
  flash_port_if.host         pins,
  input  wire logic [3:0]    address,
  input  wire logic          read,
  input  wire logic          write,
  input  wire logic [31:0]   writedata,
  output logic      [31:0]   readdata,
  output logic               waitrequest
);
  flash_port_pkg::host_state_t st_ff;
  logic [12:0] addr_ff;
  logic [15:0] wdat_ff;
  logic [15:0] rdat_ff;
  logic        dir_ff;
  logic        go_ff;
  logic        pd_ff;
  logic [2:0]  cnt_ff;
  logic [31:0] rd_ff;
  logic        ack_ff;

  ////////////////////////////////////////////////////////////////////////////
  // avalon decode; a command word: bit16 write, bit17 power-down, address low
  wire acc      = (read | write) & ~ack_ff;
  wire wr_cmd   = write & (address == flash_port_pkg::AV_CMD) & ~ack_ff;
  wire wr_wdat  = write & (address == flash_port_pkg::AV_WDATA) & ~ack_ff;
  wire busy_pin = ~pins.busy_n;
  wire [31:0] rd_mux = (address == flash_port_pkg::AV_RDATA)  ? {16'h0000, rdat_ff} :
                       (address == flash_port_pkg::AV_STATUS) ? {28'h0000000, ~pins.irq_n, ~pins.dma_request_n,
                                                                  busy_pin, go_ff} :
                       32'h00000000;
  assign waitrequest = acc;
  assign readdata    = rd_ff;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_ff  <= 1'b0;
      rd_ff   <= 32'h00000000;
      wdat_ff <= 16'h0000;
    end else begin
      ack_ff <= acc;
      rd_ff  <= rd_mux;
      if (wr_wdat) begin
        wdat_ff <= writedata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin sequencer; waits for busy release before any strobe
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_ff   <= flash_port_pkg::H_IDLE;
      addr_ff <= 13'h0000;
      dir_ff  <= 1'b0;
      go_ff   <= 1'b0;
      pd_ff   <= 1'b0;
      cnt_ff  <= 3'h0;
      rdat_ff <= 16'h0000;
    end else begin
      unique case (st_ff)
        flash_port_pkg::H_IDLE: begin
          if (wr_cmd) begin
            addr_ff <= writedata[12:0];
            dir_ff  <= writedata[16];
            pd_ff   <= writedata[17];
            go_ff   <= 1'b1;
            st_ff   <= flash_port_pkg::H_SETUP;
          end
        end
        flash_port_pkg::H_SETUP: begin
          cnt_ff <= 3'(flash_port_pkg::STROBE_CYCLES);
          if (!busy_pin) begin
            st_ff <= flash_port_pkg::H_STROBE;
          end
        end
        flash_port_pkg::H_STROBE: begin
          cnt_ff <= cnt_ff - 3'h1;
          if (cnt_ff == 3'h1) begin
            rdat_ff <= pins.bus;
            st_ff   <= flash_port_pkg::H_DONE;
          end
        end
        flash_port_pkg::H_DONE: begin
          go_ff <= 1'b0;
          st_ff <= flash_port_pkg::H_IDLE;
        end
      endcase
    end
  end

  // strobes active low during the strobe phase only
  wire strobing            = (st_ff == flash_port_pkg::H_STROBE);
  assign pins.addr               = addr_ff;
  assign pins.chip_select_n      = ~(strobing | (st_ff == flash_port_pkg::H_SETUP));
  assign pins.write_n            = ~(strobing & dir_ff);
  assign pins.read_n             = ~(strobing & ~dir_ff);
  assign pins.data_h             = wdat_ff;
  assign pins.data_h_oe          = strobing & dir_ff;
  assign pins.deep_power_down_in = pd_ff;
  assign pins.reset_in_n         = rstn;
endmodule : flash_host_end

// >>> flash_port_properties.sv
// concurrent checks on the pins between the host end and the device end
// assumes one clock domain and instantiation beside the carrier in the bench
`timescale 1ns/1ps
module flash_port_properties (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        width16_strap,
  input wire logic [1:0]  cascade_position,
  input wire logic [12:0] addr,
  input wire logic        data_d_oe,
  input wire logic        chip_select_n,
  input wire logic        write_n,
  input wire logic        read_n,
  input wire logic        busy_oe,
  input wire logic        dma_request_oe,
  input wire logic        irq_oe,
  input wire logic        narrow_mode_pullup
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////
  // straps may settle during init, so pullups are judged once busy clears
  a_pullup_follows_width:
    assert property (!busy_oe |-> narrow_mode_pullup == !width16_strap) else $error("pullup mismatch");
  a_busy_on_init:
    assert property ($rose(rstn) |-> busy_oe [*8]) else $error("busy not held at init");
  a_busy_ends:
    assert property ($rose(rstn) |-> ##[90:110] !busy_oe) else $error("busy did not end in time");
  a_no_access_busy:
    assert property (busy_oe |-> chip_select_n) else $error("access while busy");
  a_write_strobe_len:
    assert property ($fell(write_n) |-> !write_n [*4] ##1 write_n) else $error("write strobe length");
  a_read_strobe_len:
    assert property ($fell(read_n) |-> ##4 read_n) else $error("read strobe length");
  a_strobe_needs_select:
    assert property (!write_n || !read_n |-> !chip_select_n) else $error("strobe without select");
  a_drive_after_read:
    assert property (data_d_oe |-> !$past(read_n)) else $error("device drove bus unasked");
  a_foreign_silent:
    assert property (addr[12:11] != cascade_position && !read_n |-> !data_d_oe) else $error("foreign drive");
  a_requests_idle:
    assert property ($rose(rstn) |-> !dma_request_oe && !irq_oe) else $error("request after reset");
endmodule : flash_port_properties

// >>> flash_host_bus_pin_config_bench.sv
// bench: avalon host end and flash device end joined by the pin carrier
// assumes the package, carrier and both ends are compiled first
`timescale 1ns/1ps
module flash_host_bus_pin_config_bench;
  logic        clock = 0, rstn = 0, read = 0, write = 0, lock_n = 1;
  logic        width16_strap = 1, dma_event = 0, irq_event = 0;
  logic [1:0]  cascade_position = 0;
  logic [3:0]  address = 0;
  logic [31:0] writedata = 0, readdata;
  logic        waitrequest, power_down, initializing;
  logic [15:0] q;
  int          err_count = 0, samples_checked = 0, cycles = 0;
  flash_port_if pins();
  flash_dev_end u_flash_dev_end (.clock(clock), .rstn(rstn), .pins(pins), .width16_strap(width16_strap),
    .cascade_position(cascade_position), .lock_n(lock_n), .dma_event(dma_event), .irq_event(irq_event),
    .power_down(power_down), .initializing(initializing));
  flash_host_end u_flash_host_end (.clock(clock), .rstn(rstn), .pins(pins), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
  flash_port_properties u_flash_port_properties (.clock(clock), .rstn(rstn), .width16_strap(width16_strap),
    .cascade_position(cascade_position), .addr(pins.addr), .data_d_oe(pins.data_d_oe),
    .chip_select_n(pins.chip_select_n), .write_n(pins.write_n), .read_n(pins.read_n), .busy_oe(pins.busy_oe),
    .dma_request_oe(pins.dma_request_oe), .irq_oe(pins.irq_oe), .narrow_mode_pullup(pins.narrow_mode_pullup));
  ////////////////////////////////////////////////////////////
  // clock and hang guard; a hang counts as a mismatch
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      conclude();
    end
  end
  task conclude;
    if (err_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  ////////////////////////////////////////////////////////////
  // one avalon access held until waitrequest is sampled low
  task av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] v);
    @(posedge clock);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    do @(posedge clock); while (waitrequest !== 1'b0);
    v = readdata;
    read <= 0;
    write <= 0;
  endtask : av
  // one pin cycle: data word, then command, then poll go until clear
  task pin(input logic wr, input logic pd, input logic [12:0] a, input logic [15:0] d);
    logic [31:0] v;
    av(1, flash_port_pkg::AV_WDATA, {16'h0000, d}, v);
    av(1, flash_port_pkg::AV_CMD, {14'h0000, pd, wr, 3'h0, a}, v);
    do av(0, flash_port_pkg::AV_STATUS, 32'h0, v); while (v[0] !== 1'b0);
  endtask : pin
  task rd(input logic [12:0] a, output logic [15:0] v);
    logic [31:0] w;
    pin(0, 0, a, 16'h0000);
    av(0, flash_port_pkg::AV_RDATA, 32'h0, w);
    v = w[15:0];
  endtask : rd
  function automatic logic [12:0] adr(input logic [1:0] p, input logic [3:0] i, input logic b);
    return {p, 6'h00, i, b};
  endfunction : adr
  ////////////////////////////////////////////////////////////
  // reset with straps, busy through init, then pullups by width
  task do_reset(input logic wide, input logic [1:0] p);
    rstn <= 0;
    width16_strap <= wide;
    cascade_position <= p;
    repeat (20) @(posedge clock);
    rstn <= 1;
    repeat (2) @(posedge clock);
    chk("busy_n", pins.busy_n, 0);
    chk("initializing", initializing, 1);
    while (pins.busy_n !== 1'b1) @(posedge clock);
    chk("pullup", pins.narrow_mode_pullup, !wide);
  endtask : do_reset
  // own window answers, a neighbour window is neither written nor driven
  task t_cascade;
    for (int p = 0; p < 4; p++) begin
      do_reset(1, 2'(p));
      pin(1, 0, adr(2'(p), 4'h2, 0), 16'hA55A);
      pin(1, 0, adr(2'(p ^ 1), 4'h2, 0), 16'h1111);
      rd(adr(2'(p), 4'h2, 0), q);
      chk("own word", q, 16'hA55A);
      rd(adr(2'(p ^ 1), 4'h2, 0), q);
      chk("foreign word", q, 16'hFFFF);
    end
  endtask : t_cascade
  // a write under power-down is lost; the next access wakes the device
  task t_power;
    pin(1, 1, adr(cascade_position, 4'h2, 0), 16'h1111);
    chk("power_down", power_down, 1);
    rd(adr(cascade_position, 4'h2, 0), q);
    chk("pd word", q, 16'hA55A);
    chk("awake", power_down, 0);
  endtask : t_power
  // partition 0 protected under lock, partition 1 untouched
  task t_lock;
    pin(1, 0, adr(cascade_position, flash_port_pkg::IDX_CTRL, 0), 16'h0004);
    lock_n <= 0;
    pin(1, 0, adr(cascade_position, 4'h2, 0), 16'h2222);
    pin(1, 0, adr(cascade_position, 4'h9, 0), 16'h3333);
    rd(adr(cascade_position, 4'h2, 0), q);
    chk("locked read", q, 16'hFFFF);
    rd(adr(cascade_position, 4'h9, 0), q);
    chk("open part", q, 16'h3333);
    lock_n <= 1;
    rd(adr(cascade_position, 4'h2, 0), q);
    chk("unlocked", q, 16'hA55A);
  endtask : t_lock
  // each request pulls its line low and is released by its clear bit
  task t_events;
    pin(1, 0, adr(cascade_position, flash_port_pkg::IDX_CTRL, 0), 16'h0003);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) dma_event <= 1;
      else irq_event <= 1;
      @(posedge clock);
      dma_event <= 0;
      irq_event <= 0;
      repeat (3) @(posedge clock);
      chk("request low", k ? pins.irq_n : pins.dma_request_n, 0);
      pin(1, 0, adr(cascade_position, flash_port_pkg::IDX_STATUS, 0), 16'(1 << k));
      chk("request idle", k ? pins.irq_n : pins.dma_request_n, 1);
    end
  endtask : t_events
  // narrow mode: shared pin never powers down, bytes by address bit 0
  task t_narrow;
    do_reset(0, 2'b01);
    pin(1, 1, adr(2'b01, 4'h3, 0), 16'hAB34);
    chk("no pd", power_down, 0);
    pin(1, 0, adr(2'b01, 4'h3, 1), 16'h0012);
    rd(adr(2'b01, 4'h3, 0), q);
    chk("even byte", q[7:0], 8'h34);
    rd(adr(2'b01, 4'h3, 1), q);
    chk("odd byte", q[7:0], 8'h12);
  endtask : t_narrow
  initial begin
    t_cascade();
    t_power();
    t_lock();
    t_events();
    t_narrow();
    conclude();
  end
endmodule : flash_host_bus_pin_config_bench
